// file: logic/led_sup_pkg.sv
// shared constants and types for the led driver fault supervisor
package led_sup_pkg;

    // =========================================================
    // timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned INT_OSC_HZ = 350_000;
    localparam int unsigned EXT_MIN_HZ = 100_000;
    localparam int unsigned EXT_MAX_HZ = 700_000;
    // internal oscillator period in clk cycles (slightly short, rounded down)
    localparam int unsigned INT_OSC_CYC = CLK_HZ / INT_OSC_HZ;
    // no edge for two slowest periods: timing pin is strapped
    localparam int unsigned EXT_LOSS_CYC = 2 * (CLK_HZ / EXT_MIN_HZ);
    localparam int unsigned SLEEP_ENTRY_TICKS = 32768;
    localparam int unsigned BLANK_TICKS = 256;
    localparam int unsigned PER_W = 12;

    // =========================================================
    // reset values
    localparam logic GATE_RST = 1'b0;
    localparam logic FLAG_OE_RST = 1'b0;

    // =========================================================
    // types
    typedef struct packed {
        logic reg_below_off;
        logic reg_above_on;
        logic out_short;
        logic string_short;
        logic open_led;
        logic led_short;
        logic under_current;
        logic overtemp;
        logic temp_recovered;
    } fault_in_t;

    typedef enum logic [3:0] {
        ST_SLEEP  = 4'b0001,
        ST_UNDERV = 4'b0010,
        ST_BLANK  = 4'b0100,
        ST_RUN    = 4'b1000
    } sup_state_t;

endpackage : led_sup_pkg

// file: logic/pin_sync.sv
// two flip-flop synchroniser for asynchronous pins
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule : pin_sync

// file: logic/osc_select.sv
// oscillator source select, tick generation and phased clock
module osc_select
    import led_sup_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // synchronised timing pin
    input wire logic pin,
    // oscillator outputs
    output logic osc_tick,
    output logic ext_mode,
    output logic phased_clk
);
    localparam int INT_CYC = INT_OSC_CYC;
    logic pin_d;
    logic rise;
    logic [PER_W-1:0] gap;
    logic [PER_W-1:0] int_cnt;
    logic [PER_W-1:0] since_tick;
    logic [PER_W-1:0] period;
    logic int_wrap;

    assign rise = pin & ~pin_d;
    assign int_wrap = (int_cnt == PER_W'(INT_OSC_CYC - 1));

    // =========================================================
    // source detection
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_d <= 1'b0;
            gap <= '0;
            ext_mode <= 1'b0;
        end else begin
            pin_d <= pin;
            if (rise) begin
                gap <= '0;
                ext_mode <= 1'b1;
            end else if (gap == PER_W'(EXT_LOSS_CYC)) begin
                ext_mode <= 1'b0; // pin strapped to rail or ground [R6]
            end else begin
                gap <= gap + 1'b1;
            end
        end
    end

    // =========================================================
    // tick
    always_ff @(posedge clk) begin
        if (srst) begin
            int_cnt <= '0;
            osc_tick <= 1'b0;
        end else begin
            int_cnt <= int_wrap ? '0 : int_cnt + 1'b1; // [R6]
            osc_tick <= ext_mode ? rise : int_wrap; // [R7]
        end
    end

    // =========================================================
    // phased clock: rises half a period after own switching point
    always_ff @(posedge clk) begin
        if (srst) begin
            since_tick <= '0;
            period <= PER_W'(INT_OSC_CYC);
            phased_clk <= 1'b0;
        end else if (osc_tick) begin
            since_tick <= '0;
            period <= since_tick + 1'b1;
            phased_clk <= 1'b0;
        end else begin
            if (since_tick != '1) begin
                since_tick <= since_tick + 1'b1;
            end
            if (since_tick == (period >> 1)) begin
                phased_clk <= 1'b1; // [R8]
            end
        end
    end

    a_int_period: assert property (@(posedge clk) disable iff (srst) // [R6]
        (osc_tick && !ext_mode) |-> ##INT_CYC (osc_tick || ext_mode))
        else $error("internal tick spacing wrong");
    a_ext_follow: assert property (@(posedge clk) disable iff (srst) // [R7]
        (ext_mode && rise) |=> osc_tick)
        else $error("external edge did not tick");
    a_phase_late: assert property (@(posedge clk) disable iff (srst) // [R8]
        osc_tick |=> !phased_clk ##1 !phased_clk)
        else $error("phased clock not delayed");

endmodule : osc_select

// file: logic/led_fault_supervisor.sv
// digital supervisor of a constant-current led converter
// Summary of operation
// R1 - long low enable puts device to sleep
// R2 - sleep time is 32768 oscillator periods
// R3 - gate drive off while enable low
// R4 - led current full when high, zero low
// R5 - host keeps pwm period below sleep time
// R6 - strapped timing pin runs internal 350 kHz
// R7 - external clock 100-700 kHz drives switching
// R8 - phased clock lags own switching point
// R9 - flags pull low unless fault, open otherwise
// R10 - unlatched flags follow their fault condition
// R11 - shorts latch, critical flag, gate off
// R12 - open led latches until enable low
// R13 - faults ignored during start-up blanking
// R14 - open led bypasses blanking, acts immediately
// R15 - undervoltage gates off, releases both flags
// R16 - undercurrent flags general, keeps driving
// R17 - overtemperature flags general, hysteresis recovery
// R18 - held-low critical flag overrides short disable
// R19 - held-low general flag overrides open disable
// R20 - blanking counted in oscillator ticks
// R21 - flags are registered fault OR per tick
module led_fault_supervisor
    import led_sup_pkg::*;
#(
    parameter int unsigned SLEEP_TICKS = SLEEP_ENTRY_TICKS,
    parameter int unsigned BLANK_LEN = BLANK_TICKS
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // host side
    input wire logic enable_pwm_in,
    input wire logic critical_fault_flag_in,
    output logic critical_fault_flag_out,
    output logic critical_fault_flag_oe,
    input wire logic general_fault_flag_in,
    output logic general_fault_flag_out,
    output logic general_fault_flag_oe,
    // oscillator
    input wire logic timing_pin_in,
    output logic phased_clock_out,
    // analog side
    input wire fault_in_t fault_in,
    output logic gate_drive_out,
    output logic led_current_full,
    output logic sleep_active
);
    localparam int FW = $bits(fault_in_t);
    localparam int LOW_W = $clog2(SLEEP_TICKS + 1);
    localparam int BLK_W = $clog2(BLANK_LEN + 1);

    // =========================================================
    // input synchronisation
    logic [FW+3:0] raw_in;
    logic [FW+3:0] sync_in;
    logic en;
    logic timing_pin;
    logic crit_pin;
    logic gen_pin;
    fault_in_t flt;

    assign raw_in = {enable_pwm_in, timing_pin_in, critical_fault_flag_in,
                     general_fault_flag_in, fault_in};
    assign en = sync_in[FW+3];
    assign timing_pin = sync_in[FW+2];
    assign crit_pin = sync_in[FW+1];
    assign gen_pin = sync_in[FW];
    assign flt = fault_in_t'(sync_in[FW-1:0]);

    pin_sync #(
        .W(FW + 4)
    ) u_sync (
        .clk(clk),
        .srst(srst),
        .d(raw_in),
        .q(sync_in)
    );

    // =========================================================
    // oscillator
    logic osc_tick;
    logic ext_mode;
    logic phased_clk;

    osc_select u_osc (
        .clk(clk),
        .srst(srst),
        .pin(timing_pin),
        .osc_tick(osc_tick),
        .ext_mode(ext_mode),
        .phased_clk(phased_clk)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            phased_clock_out <= 1'b0;
        end else begin
            phased_clock_out <= phased_clk & ~sleep_active; // [R8]
        end
    end

    // =========================================================
    // sleep timer, counted in oscillator periods
    logic [LOW_W-1:0] low_ticks;
    logic sleep_hit;

    assign sleep_hit = (low_ticks == LOW_W'(SLEEP_TICKS));

    always_ff @(posedge clk) begin
        if (srst || en) begin
            low_ticks <= '0;
        end else if (osc_tick && !sleep_hit) begin
            low_ticks <= low_ticks + 1'b1; // [R2]
        end
    end

    // =========================================================
    // regulator and temperature hysteresis
    logic uv_state;
    logic ot_state;

    always_ff @(posedge clk) begin
        if (srst) begin
            uv_state <= 1'b1;
        end else if (flt.reg_below_off) begin
            uv_state <= 1'b1;
        end else if (flt.reg_above_on) begin
            uv_state <= 1'b0; // only the higher turn-on level re-enables [R15]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ot_state <= 1'b0;
        end else if (flt.overtemp) begin
            ot_state <= 1'b1;
        end else if (flt.temp_recovered) begin
            ot_state <= 1'b0; // [R17]
        end
    end

    // =========================================================
    // supervisor state
    sup_state_t state;
    sup_state_t next_state;
    logic [BLK_W-1:0] blank_cnt;
    logic blank_done;

    assign blank_done = (blank_cnt == BLK_W'(BLANK_LEN));

    always_comb begin
        next_state = state;
        unique case (state)
            ST_SLEEP: begin
                if (en) begin
                    next_state = uv_state ? ST_UNDERV : ST_BLANK;
                end
            end
            ST_UNDERV: begin
                if (!uv_state) begin
                    next_state = ST_BLANK;
                end
            end
            ST_BLANK: begin
                if (blank_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_SLEEP;
            end
        endcase
        if (state != ST_SLEEP) begin
            if (sleep_hit) begin
                next_state = ST_SLEEP; // [R1]
            end else if (uv_state) begin
                next_state = ST_UNDERV; // [R15]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= ST_SLEEP;
        end else begin
            state <= next_state;
        end
    end

    // blanking restarts whenever sleep or undervoltage is left
    always_ff @(posedge clk) begin
        if (srst || state != ST_BLANK) begin
            blank_cnt <= '0;
        end else if (osc_tick && !blank_done) begin
            blank_cnt <= blank_cnt + 1'b1; // [R20]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sleep_active <= 1'b1;
        end else begin
            sleep_active <= (next_state == ST_SLEEP); // [R1]
        end
    end

    // =========================================================
    // fault latches
    logic monitor;
    logic active;
    logic short_latch;
    logic open_latch;
    logic crit_override;
    logic gen_override;
    logic [1:0] crit_oe_d;
    logic [1:0] gen_oe_d;

    assign monitor = (state == ST_RUN); // [R13]
    assign active = (state == ST_BLANK) || (state == ST_RUN);

    // cleared only by sleep entry or reset
    always_ff @(posedge clk) begin
        if (srst) begin
            short_latch <= 1'b0;
        end else if (monitor && (flt.out_short || flt.string_short)) begin
            short_latch <= 1'b1; // [R11]
        end else if (state == ST_SLEEP) begin
            short_latch <= 1'b0; // [R11]
        end
    end

    // no blanking: open output can build a hazardous voltage
    always_ff @(posedge clk) begin
        if (srst) begin
            open_latch <= 1'b0;
        end else if (active && en && flt.open_led) begin
            open_latch <= 1'b1; // [R12] [R14]
        end else if (!en) begin
            open_latch <= 1'b0; // [R12]
        end
    end

    // pin seen low only counts once our own pull-down has been off for
    // the synchroniser depth, else our sink would re-enable the gate
    assign crit_override = short_latch && !crit_pin && !critical_fault_flag_oe &&
                           (crit_oe_d == 2'h0); // [R18]
    assign gen_override = (open_latch || flt.open_led) && !gen_pin &&
                          !general_fault_flag_oe && (gen_oe_d == 2'h0); // [R19]

    // =========================================================
    // gate drive and current level
    logic next_gate;

    always_comb begin
        next_gate = en && active && !uv_state; // [R3] [R15]
        if (short_latch && !crit_override) begin
            next_gate = 1'b0; // [R11]
        end
        if ((open_latch || (active && flt.open_led)) && !gen_override) begin
            next_gate = 1'b0; // [R12] [R14]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            gate_drive_out <= GATE_RST;
            led_current_full <= 1'b0;
        end else begin
            gate_drive_out <= next_gate;
            led_current_full <= en && active; // [R4]
        end
    end

    // =========================================================
    // fault flags, open drain: enable high means pulling low
    logic crit_rel;
    logic gen_rel;

    // undercurrent keeps the gate running [R16]
    assign crit_rel = uv_state || short_latch; // [R10] [R15]
    assign gen_rel = uv_state || open_latch ||
                     (monitor && (flt.under_current || ot_state || flt.led_short));

    always_ff @(posedge clk) begin
        if (srst) begin
            critical_fault_flag_oe <= FLAG_OE_RST;
            general_fault_flag_oe <= FLAG_OE_RST;
        end else if (state == ST_SLEEP) begin
            critical_fault_flag_oe <= 1'b0;
            general_fault_flag_oe <= 1'b0;
        end else if (osc_tick) begin
            critical_fault_flag_oe <= ~crit_rel; // [R9] [R21]
            general_fault_flag_oe <= ~gen_rel; // [R9] [R16] [R17] [R21]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            critical_fault_flag_out <= 1'b0;
            general_fault_flag_out <= 1'b0;
            crit_oe_d <= 2'h0;
            gen_oe_d <= 2'h0;
        end else begin
            critical_fault_flag_out <= 1'b0;
            general_fault_flag_out <= 1'b0;
            // flag history for the override check
            crit_oe_d <= {crit_oe_d[0], critical_fault_flag_oe};
            gen_oe_d <= {gen_oe_d[0], general_fault_flag_oe};
        end
    end

    // =========================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    a_sleep_entry: assert property ( // [R1]
        (sleep_hit && state != ST_SLEEP) |=> state == ST_SLEEP ##1 sleep_active)
        else $error("no sleep after long low");
    a_sleep_count: assert property ( // [R2]
        (state != ST_SLEEP) ##1 (state == ST_SLEEP) |-> $past(low_ticks) == SLEEP_TICKS)
        else $error("sleep entered at wrong count");
    a_pwm_gate: assert property ( // [R3]
        !en |=> !gate_drive_out)
        else $error("gate driven with enable low");
    a_pwm_level: assert property ( // [R4]
        (en && active) |=> led_current_full)
        else $error("led current level wrong");
    a_flag_idle: assert property ( // [R9]
        (osc_tick && monitor && !crit_rel) |=> critical_fault_flag_oe)
        else $error("critical flag not pulling low");
    a_short_hold: assert property ( // [R11]
        (short_latch && state != ST_SLEEP) |=> short_latch)
        else $error("short latch lost early");
    a_blank_mask: assert property ( // [R13]
        (state == ST_BLANK && !short_latch) |=> !short_latch)
        else $error("short caught during blanking");
    a_open_fast: assert property ( // [R14]
        (active && flt.open_led && !gen_override) |=> !gate_drive_out)
        else $error("open led did not stop gate");
    a_uv_gate: assert property ( // [R15]
        uv_state |=> !gate_drive_out)
        else $error("gate active in undervoltage");
    a_crit_ovr: assert property ( // [R18]
        (crit_override && en && active && !open_latch && !flt.open_led && !uv_state)
        |=> gate_drive_out)
        else $error("critical override ignored");

endmodule : led_fault_supervisor

// file: sim/host_model.sv
// host controller model: enable driver and open-drain flag wires
module host_model (
    // clock
    input wire logic clk,
    // bench commands
    input wire logic en_cmd,
    input wire logic hold_crit,
    input wire logic hold_gen,
    // device flag drivers
    input wire logic crit_out,
    input wire logic crit_oe,
    input wire logic gen_out,
    input wire logic gen_oe,
    // resolved wires
    output logic enable_pwm,
    output logic crit_wire,
    output logic gen_wire
);
    timeunit 1ns;
    timeprecision 1ps;

    // =========================================================
    // enable and flags
    // bench keeps pwm low phases well short of the sleep time; sc_short holds enable low until sleep
    assign enable_pwm = en_cmd;
    // pull-ups: a wire is low only while someone sinks it
    assign crit_wire = ((crit_oe && !crit_out) || hold_crit) ? 1'b0 : 1'b1;
    assign gen_wire = ((gen_oe && !gen_out) || hold_gen) ? 1'b0 : 1'b1;
endmodule : host_model

// file: sim/tb_top.sv
// self-checking bench for the led driver fault supervisor
module tb_top
    import led_sup_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // =========================================================
    // signals
    localparam int SLP = 8;
    localparam int BLK = 4;
    localparam int OSC = INT_OSC_CYC;
    localparam int FW = OSC + 20;
    logic clk;
    logic srst;
    logic en_cmd;
    logic hold_crit;
    logic hold_gen;
    logic enable_pwm;
    logic crit_wire;
    logic gen_wire;
    logic crit_out;
    logic crit_oe;
    logic gen_out;
    logic gen_oe;
    logic timing_pin;
    logic phased;
    logic gate;
    logic lcf;
    logic sleep;
    logic ext_on;
    fault_in_t faults;
    int tcnt;
    int n_fail;
    int checks_done;

    host_model host_model_i (
        .clk(clk), .en_cmd(en_cmd), .hold_crit(hold_crit), .hold_gen(hold_gen),
        .crit_out(crit_out), .crit_oe(crit_oe), .gen_out(gen_out), .gen_oe(gen_oe),
        .enable_pwm(enable_pwm), .crit_wire(crit_wire), .gen_wire(gen_wire)
    );

    led_fault_supervisor #(.SLEEP_TICKS(SLP), .BLANK_LEN(BLK)) led_fault_supervisor_i (
        .clk(clk), .srst(srst), .enable_pwm_in(enable_pwm),
        .critical_fault_flag_in(crit_wire), .critical_fault_flag_out(crit_out),
        .critical_fault_flag_oe(crit_oe), .general_fault_flag_in(gen_wire),
        .general_fault_flag_out(gen_out), .general_fault_flag_oe(gen_oe),
        .timing_pin_in(timing_pin), .phased_clock_out(phased), .fault_in(faults),
        .gate_drive_out(gate), .led_current_full(lcf), .sleep_active(sleep)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // external clock at 500 kHz
    always @(posedge clk) begin
        if (ext_on) begin
            tcnt <= (tcnt == 99) ? 0 : tcnt + 1;
            if (tcnt == 99)
                timing_pin <= !timing_pin;
        end
    end

    // =========================================================
    // helpers
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic pick(input int sel);
        case (sel)
            0: return gate;
            1: return sleep;
            2: return gen_oe;
            3: return crit_oe;
            5: return phased;
            default: return timing_pin;
        endcase
    endfunction : pick

    // bounded wait; running out ends the run
    task automatic wait_for(input int sel, input logic val, input int bound, output int n);
        n = 0;
        while (pick(sel) !== val && n < bound) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(pick(sel), val);
        if (pick(sel) !== val)
            summarize();
    endtask : wait_for

    task automatic hold(input int sel, input logic val, input int cyc);
        int bad;
        bad = 0;
        repeat (cyc) begin
            @(posedge clk);
            #1;
            if (pick(sel) !== val)
                bad++;
        end
        chk(bad, 0);
    endtask : hold

    task automatic en(input logic v);
        @(posedge clk);
        en_cmd <= v;
    endtask : en

    task automatic setf(input int k, input logic v);
        @(posedge clk);
        case (k)
            0: faults.out_short <= v;
            1: faults.string_short <= v;
            2: faults.under_current <= v;
            3: faults.led_short <= v;
            4: faults.overtemp <= v;
            5: faults.open_led <= v;
            6: faults.reg_below_off <= v;
            7: faults.reg_above_on <= v;
            default: faults.temp_recovered <= v;
        endcase
    endtask : setf

    task automatic per(output int p);
        int a;
        int b;
        wait_for(5, 1'b0, 1000, a);
        wait_for(5, 1'b1, 1000, a);
        wait_for(5, 1'b0, 1000, a);
        wait_for(5, 1'b1, 1000, b);
        p = a + b;
    endtask : per

    // =========================================================
    // scenarios
    task automatic sc_wake();
        int n;
        // undercurrent present from wake: masked until blanking ends
        setf(2, 1'b1);
        en(1'b1);
        wait_for(0, 1'b1, 8, n);
        chk(lcf, 1'b1);
        wait_for(2, 1'b1, 2 * OSC, n);
        chk(crit_oe, 1'b1);
        wait_for(2, 1'b0, (BLK + 2) * OSC, n);
        chk(n >= (BLK - 1) * OSC, 1'b1);
        setf(2, 1'b0);
        wait_for(2, 1'b1, FW, n);
    endtask : sc_wake

    task automatic sc_pwm();
        int n;
        repeat (3) begin
            en(1'b0);
            wait_for(0, 1'b0, 5, n);
            chk(lcf, 1'b0);
            hold(1, 1'b0, 1000);
            en(1'b1);
            wait_for(0, 1'b1, 5, n);
            chk(lcf, 1'b1);
        end
    endtask : sc_pwm

    task automatic sc_general(input int k);
        int n;
        if (k == 4)
            setf(8, 1'b0);
        setf(k, 1'b1);
        wait_for(2, 1'b0, FW, n);
        chk(crit_oe, 1'b1);
        hold(0, 1'b1, 50);
        setf(k, 1'b0);
        if (k == 4) begin
            // still hot until the recovery point is crossed
            hold(2, 1'b0, 2 * OSC);
            setf(8, 1'b1);
        end
        wait_for(2, 1'b1, FW, n);
    endtask : sc_general

    task automatic sc_short(input int k);
        int n;
        setf(k, 1'b1);
        wait_for(0, 1'b0, 8, n);
        wait_for(3, 1'b0, FW, n);
        chk(gen_oe, 1'b1);
        setf(k, 1'b0);
        hold(0, 1'b0, 2 * OSC);
        @(posedge clk);
        hold_crit <= 1'b1;
        wait_for(0, 1'b1, 8, n);
        @(posedge clk);
        hold_crit <= 1'b0;
        wait_for(0, 1'b0, 8, n);
        en(1'b0);
        repeat (50) @(posedge clk);
        en(1'b1);
        hold(0, 1'b0, 20);
        en(1'b0);
        wait_for(1, 1'b1, (SLP + 1) * OSC + 20, n);
        chk(n >= (SLP - 1) * OSC, 1'b1);
        @(posedge clk);
        #1;
        chk({gate, gen_oe, crit_oe, phased}, 4'h0);
        sc_wake();
        chk(crit_oe, 1'b1);
    endtask : sc_short

    task automatic sc_uv();
        int n;
        setf(6, 1'b1);
        setf(7, 1'b0);
        wait_for(0, 1'b0, 8, n);
        wait_for(2, 1'b0, FW, n);
        chk(crit_oe, 1'b0);
        setf(6, 1'b0);
        hold(0, 1'b0, 100);
        setf(7, 1'b1);
        wait_for(0, 1'b1, 8, n);
        setf(5, 1'b1);
        wait_for(0, 1'b0, 8, n);
        setf(5, 1'b0);
        hold(0, 1'b0, 50);
        wait_for(2, 1'b0, FW, n);
        @(posedge clk);
        hold_gen <= 1'b1;
        wait_for(0, 1'b1, 8, n);
        @(posedge clk);
        hold_gen <= 1'b0;
        wait_for(0, 1'b0, 8, n);
        en(1'b0);
        repeat (20) @(posedge clk);
        en(1'b1);
        wait_for(0, 1'b1, 8, n);
        wait_for(2, 1'b1, (BLK + 2) * OSC, n);
    endtask : sc_uv

    task automatic sc_osc();
        int n;
        int p;
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            timing_pin <= s[0];
            // strap change must outlast the loss detector
            repeat (2500) @(posedge clk);
            per(p);
            chk(p, OSC);
        end
        @(posedge clk);
        ext_on <= 1'b1;
        repeat (1000) @(posedge clk);
        per(p);
        chk(p, 200);
        wait_for(6, 1'b0, 200, n);
        wait_for(6, 1'b1, 200, n);
        wait_for(5, 1'b0, 20, n);
        chk(n >= 1 && n <= 10, 1'b1);
        @(posedge clk);
        ext_on <= 1'b0;
        @(posedge clk);
        timing_pin <= 1'b0;
        repeat (2500) @(posedge clk);
        per(p);
        chk(p, OSC);
    endtask : sc_osc

    // =========================================================
    // main sequence
    initial begin
        srst = 1'b1;
        en_cmd = 1'b0;
        hold_crit = 1'b0;
        hold_gen = 1'b0;
        timing_pin = 1'b0;
        ext_on = 1'b0;
        tcnt = 0;
        faults = '0;
        faults.reg_above_on = 1'b1;
        faults.temp_recovered = 1'b1;
        n_fail = 0;
        checks_done = 0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        chk({gate, lcf, sleep, gen_oe, crit_oe, phased}, 6'h08);
        sc_wake();
        sc_pwm();
        for (int k = 2; k < 5; k++)
            sc_general(k);
        for (int k = 0; k < 2; k++)
            sc_short(k);
        sc_uv();
        sc_osc();
        summarize();
    end
endmodule : tb_top
